// ===== dsm_select.sv
// Modulator source and high carrier select block with Avalon-MM registers.
// What this block does
// - Codes 1111-1100 cells 4-1, 1011 oscillator.
// - 1010 serial tx, 1001/1000 serial data outs.
// - 0111-0110 comparators, 0101-0100 pulse generators.
// - 0011-0010 capture units in pwm; 0001 pin.
// - Unimplemented bits read zero, ignore writes.
// - Fields cleared to zero at power-on, kept otherwise.
// - Sync set: wait high-carrier falling edge.
// - Sync clear: switch away from carrier immediately.
// - Unsynchronised glitches need not be suppressed.
`timescale 1ns/1ps
`default_nettype none
module dsm_select
  import dsm_pkg::*;
(
  // Clock and resets.
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_reset_i,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Sources and carriers.
  input wire dsm_src_t src_i,
  input wire logic modulator_pin_input_mapping_i,
  input wire logic high_carrier_i,
  input wire logic want_low_i,
  // Results.
  output logic source_o,
  output logic high_carrier_o,
  output logic use_low_o,
  output logic [3:0] high_carrier_select_field_o
);

  logic [7:0] modulation_source_select_q; // Source select register.
  logic [7:0] high_carrier_control_q; // High carrier control register.
  logic pin_meta_q; // First synchroniser stage.
  logic pin_sync_q; // Second synchroniser stage.
  logic ack_q; // One-cycle answer to a held request.
  logic [31:0] readdata_q; // Registered read data.
  logic wr_go;
  logic rd_go;

  // Requests complete one cycle after they appear.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_go = avs_write_i & ~avs_waitrequest_o;
  assign rd_go = avs_read_i & ~avs_waitrequest_o;
  assign avs_readdata_o = readdata_q;

  // Answer pulse.
  always_ff @(posedge clk_i) begin
    if (reset_i | por_reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  // Registers: only power-on reset clears them, other resets keep them.
  always_ff @(posedge clk_i) begin
    if (por_reset_i) begin
      modulation_source_select_q <= DSM_POR_VALUE;
      high_carrier_control_q <= DSM_POR_VALUE;
    end else if (wr_go && !reset_i && avs_byteenable_i[0]) begin
      // A write that completes on a warm reset edge is dropped so the reset keeps the fields.
      if (avs_address_i == DSM_SRC_ADDR) begin
        modulation_source_select_q <= avs_writedata_i[7:0] & DSM_SRC_MASK;
      end else if (avs_address_i == DSM_CARH_ADDR) begin
        high_carrier_control_q <= avs_writedata_i[7:0] & DSM_CARH_MASK;
      end
    end
  end

  // Read data; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    if (reset_i | por_reset_i) begin
      readdata_q <= 32'h0;
    end else if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        DSM_SRC_ADDR: readdata_q <= {24'h0, modulation_source_select_q};
        DSM_CARH_ADDR: readdata_q <= {24'h0, high_carrier_control_q};
        default: readdata_q <= 32'h0;
      endcase
    end
  end

  // Pin input synchroniser.
  always_ff @(posedge clk_i) begin
    if (reset_i | por_reset_i) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= modulator_pin_input_mapping_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign high_carrier_select_field_o = high_carrier_control_q[3:0];

  // Source multiplexer.
  dsm_source_mux u_mux (
    .src_i(src_i),
    .pin_sync_i(pin_sync_q),
    .sel_i(modulation_source_select_q[3:0]),
    .source_o(source_o)
  );

  // High carrier handling.
  dsm_carrier_high u_carh (
    .clk_i(clk_i),
    .reset_i(reset_i | por_reset_i),
    .polarity_i(high_carrier_control_q[DSM_CH_POL_BIT]),
    .sync_en_i(high_carrier_control_q[DSM_CH_SYNC_BIT]),
    .carrier_i(high_carrier_i),
    .want_low_i(want_low_i),
    .carrier_o(high_carrier_o),
    .use_low_o(use_low_o)
  );

  resv_zero_a: assert property (@(posedge clk_i) disable iff (por_reset_i)
    (modulation_source_select_q & ~DSM_SRC_MASK) == 8'h0 &&
    (high_carrier_control_q & ~DSM_CARH_MASK) == 8'h0)
    else $error("reserved bit set");
  keep_reset_a: assert property (@(posedge clk_i) disable iff (por_reset_i)
    reset_i |=> $stable(high_carrier_control_q))
    else $error("register lost on warm reset");
  pol_inv_a: assert property (@(posedge clk_i) disable iff (reset_i)
    high_carrier_o == (high_carrier_i ^ high_carrier_control_q[DSM_CH_POL_BIT]))
    else $error("polarity wrong");
  cell_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
    modulation_source_select_q[3:0] == 4'hf |-> source_o == src_i.logic_cell_out[3])
    else $error("cell 4 not routed");
  uart_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
    modulation_source_select_q[3:0] == DSM_SRC_UART |-> source_o == src_i.async_serial_tx)
    else $error("serial tx not routed");
  cmp_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
    modulation_source_select_q[3:0] == DSM_SRC_CMP2 |-> source_o == src_i.comparator_2_out)
    else $error("comparator not routed");
  pin_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
    modulation_source_select_q[3:0] == DSM_SRC_PIN |-> source_o == pin_sync_q)
    else $error("pin not routed");
  bus_ack_a: assert property (@(posedge clk_i) disable iff (reset_i | por_reset_i)
    (avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  wr_cov_c: cover property (@(posedge clk_i) wr_go);
  rd_cov_c: cover property (@(posedge clk_i) rd_go);
  pin_cov_c: cover property (@(posedge clk_i) modulation_source_select_q[3:0] == DSM_SRC_PIN);

endmodule
`default_nettype wire

// ===== dsm_pkg.sv
// Package with register map, field layout, codes and source input type for the modulator select.
package dsm_pkg;

  // Register byte addresses on the word-addressed bus (word index times four).
  localparam logic [3:0] DSM_SRC_ADDR = 4'h0;
  localparam logic [3:0] DSM_CARH_ADDR = 4'h4;

  // Source select register field layout.
  localparam int DSM_SRC_LSB = 0;
  localparam logic [7:0] DSM_SRC_MASK = 8'h0f;

  // High carrier control register field layout.
  localparam int DSM_CH_SEL_LSB = 0;
  localparam int DSM_CH_SYNC_BIT = 5;
  localparam int DSM_CH_POL_BIT = 6;
  localparam logic [7:0] DSM_CARH_MASK = 8'h6f;

  // Value loaded at power-on reset; other resets keep the fields.
  localparam logic [7:0] DSM_POR_VALUE = 8'h00;

  // Source select codes.
  localparam logic [3:0] DSM_SRC_PIN = 4'h1;
  localparam logic [3:0] DSM_SRC_CAPTURE_COMPARE_1_OUT = 4'h2;
  localparam logic [3:0] DSM_SRC_CAPTURE_COMPARE_2_OUT = 4'h3;
  localparam logic [3:0] DSM_SRC_PWA = 4'h4;
  localparam logic [3:0] DSM_SRC_PWB = 4'h5;
  localparam logic [3:0] DSM_SRC_CMP1 = 4'h6;
  localparam logic [3:0] DSM_SRC_CMP2 = 4'h7;
  localparam logic [3:0] DSM_SRC_SSP1 = 4'h8;
  localparam logic [3:0] DSM_SRC_SSP2 = 4'h9;
  localparam logic [3:0] DSM_SRC_UART = 4'ha;
  localparam logic [3:0] DSM_SRC_NCO = 4'hb;
  localparam logic [3:0] DSM_SRC_CELL1 = 4'hc;

  // Modulating source inputs from on-chip peripherals.
  typedef struct packed {
    logic [3:0] logic_cell_out;
    logic num_osc_1_out;
    logic async_serial_tx;
    logic serial_data_out_2;
    logic serial_data_out_1;
    logic comparator_2_out;
    logic comparator_1_out;
    logic pulse_gen_b_out;
    logic pulse_gen_a_out;
    logic capture_compare_2_out;
    logic capture_compare_1_out;
    logic [1:0] capture_compare_pwm_mode;
  } dsm_src_t;

endpackage

// ===== dsm_source_mux.sv
// Modulating source multiplexer driven by the source select field.
`timescale 1ns/1ps
`default_nettype none
module dsm_source_mux
  import dsm_pkg::*;
(
  // Inputs.
  input wire dsm_src_t src_i,
  input wire logic pin_sync_i,
  input wire logic [3:0] sel_i,
  // Output.
  output logic source_o
);

  // Pick one source; capture/compare units count only in pulse-width mode.
  always_comb begin
    source_o = 1'b0;
    if (sel_i >= DSM_SRC_CELL1) begin
      // Codes 12 to 15 map to cells 1 to 4, so the two low bits of the offset suffice.
      source_o = src_i.logic_cell_out[2'(sel_i - DSM_SRC_CELL1)];
    end else begin
      case (sel_i)
        DSM_SRC_NCO: source_o = src_i.num_osc_1_out;
        DSM_SRC_UART: source_o = src_i.async_serial_tx;
        DSM_SRC_SSP2: source_o = src_i.serial_data_out_2;
        DSM_SRC_SSP1: source_o = src_i.serial_data_out_1;
        DSM_SRC_CMP2: source_o = src_i.comparator_2_out;
        DSM_SRC_CMP1: source_o = src_i.comparator_1_out;
        DSM_SRC_PWB: source_o = src_i.pulse_gen_b_out;
        DSM_SRC_PWA: source_o = src_i.pulse_gen_a_out;
        DSM_SRC_CAPTURE_COMPARE_2_OUT: begin
          source_o = src_i.capture_compare_2_out & src_i.capture_compare_pwm_mode[1];
        end
        DSM_SRC_CAPTURE_COMPARE_1_OUT: begin
          source_o = src_i.capture_compare_1_out & src_i.capture_compare_pwm_mode[0];
        end
        DSM_SRC_PIN: source_o = pin_sync_i;
        default: source_o = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== dsm_carrier_high.sv
// High carrier polarity and switch synchronisation.
`timescale 1ns/1ps
`default_nettype none
module dsm_carrier_high
  import dsm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Controls.
  input wire logic polarity_i,
  input wire logic sync_en_i,
  // Carrier and request.
  input wire logic carrier_i,
  input wire logic want_low_i,
  // Results.
  output logic carrier_o,
  output logic use_low_o
);

  logic carrier_q; // Previous polarised carrier for edge detection.
  logic use_low_q; // Registered switch state.
  logic fall;

  // Invert the carrier when polarity is set.
  assign carrier_o = carrier_i ^ polarity_i;
  assign fall = carrier_q & ~carrier_o;

  // Remember the carrier level.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      carrier_q <= 1'b0;
    end else begin
      carrier_q <= carrier_o;
    end
  end

  // Switch to low carrier only on a falling edge when synchronised.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      use_low_q <= 1'b0;
    end else if (!want_low_i) begin
      use_low_q <= 1'b0;
    end else if (fall) begin
      use_low_q <= 1'b1;
    end
  end

  // Unsynchronised mode switches at once; glitches are accepted.
  assign use_low_o = sync_en_i ? use_low_q : want_low_i;

  hold_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
    sync_en_i && want_low_i && !use_low_q && !fall |=> !use_low_q)
    else $error("switch happened without a falling edge");
  direct_switch_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !sync_en_i |-> use_low_o == want_low_i)
    else $error("unsynchronised switch not immediate");
  sync_cov_c: cover property (@(posedge clk_i) disable iff (reset_i)
    sync_en_i && want_low_i && fall ##1 use_low_o);

endmodule
`default_nettype wire

// ===== dsm_select_test.sv
// Self-checking testbench for the modulator source and high carrier select block.
`timescale 1ns/1ps
`default_nettype none
module dsm_select_test;
  import dsm_pkg::*;
  // Clock, resets and bus signals.
  logic clk_i, reset_i, por_reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0] avs_address_i, avs_byteenable_i, hsel;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  // Sources, carrier and results.
  logic pin_i, carrier_i, want_low_i, source_o, high_carrier_o, use_low_o;
  dsm_src_t src_i;
  // Counters for checks, mismatches and elapsed cycles.
  int fails, n_tests, cyc, seed_v, c;

  dsm_select dut (.clk_i(clk_i), .reset_i(reset_i), .por_reset_i(por_reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .src_i(src_i), .modulator_pin_input_mapping_i(pin_i), .high_carrier_i(carrier_i),
    .want_low_i(want_low_i), .source_o(source_o), .high_carrier_o(high_carrier_o),
    .use_low_o(use_low_o), .high_carrier_select_field_o(hsel));

  // The 40 MHz system clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Compares a seen value with the model and counts the result.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // One bus cycle; the request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // Only the bench timeout ends this wait.
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // One idle edge keeps the strobes from being driven twice in one step.
    @(posedge clk_i);
  endtask

  // Behavioural model of the source selection.
  function automatic logic exp_src(input int code, input dsm_src_t s, input logic p);
    case (code)
      12, 13, 14, 15: return s.logic_cell_out[code-12];
      11: return s.num_osc_1_out;
      10: return s.async_serial_tx;
      9: return s.serial_data_out_2;
      8: return s.serial_data_out_1;
      7: return s.comparator_2_out;
      6: return s.comparator_1_out;
      5: return s.pulse_gen_b_out;
      4: return s.pulse_gen_a_out;
      // Capture units count only in their pulse-width mode.
      3: return s.capture_compare_2_out & s.capture_compare_pwm_mode[1];
      2: return s.capture_compare_1_out & s.capture_compare_pwm_mode[0];
      1: return p;
      default: return 1'b0;
    endcase
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end

  // Main sequence of tests.
  initial begin
    {avs_read_i, avs_write_i, pin_i, carrier_i, want_low_i} = 5'h00;
    {avs_address_i, avs_byteenable_i, avs_writedata_i, src_i} = '0;
    {reset_i, por_reset_i} = 2'h3;
    seed_v = $urandom(39411);
    repeat (2) @(posedge clk_i);
    {reset_i, por_reset_i} <= 2'h0;
    @(posedge clk_i);
    bus(1'b0, DSM_SRC_ADDR, 32'h0, 4'hf);
    chk(rd, 32'h0, "power-on value");
    $display("test reset done");
    // Reserved bits, unmapped place and a write without lane zero.
    bus(1'b1, DSM_SRC_ADDR, 32'hffffffff, 4'hf);
    bus(1'b0, DSM_SRC_ADDR, 32'h0, 4'hf);
    chk(rd, 32'h0000000f, "source reserved bits");
    bus(1'b1, DSM_CARH_ADDR, 32'hffffffff, 4'hf);
    bus(1'b0, DSM_CARH_ADDR, 32'h0, 4'hf);
    chk(rd, 32'h0000006f, "carrier reserved bits");
    chk({28'h0, hsel}, 32'hf, "carrier select field");
    bus(1'b1, 4'h8, 32'h5, 4'hf);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, DSM_SRC_ADDR, 32'h3, 4'he);
    reset_i <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, DSM_SRC_ADDR, 32'h0, 4'hf);
    chk(rd, 32'h0000000f, "kept over warm reset");
    $display("test registers done");
    // Every code twice with random source values.
    for (int r = 0; r < 32; r++) begin
      c = r % 16;
      src_i <= dsm_src_t'(16'($urandom));
      pin_i <= 1'($urandom);
      bus(1'b1, DSM_SRC_ADDR, 32'(c), 4'hf);
      repeat (3) @(posedge clk_i);
      chk({31'h0, source_o}, {31'h0, exp_src(c, src_i, pin_i)}, "src");
    end
    $display("test sources done");
    // Polarity and unsynchronised switching.
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, DSM_CARH_ADDR, 32'(p << 6), 4'hf);
      for (int k = 0; k < 4; k++) begin
        carrier_i <= k[0];
        want_low_i <= k[1];
        repeat (2) @(posedge clk_i);
        chk({31'h0, high_carrier_o}, 32'(k[0] ^ p[0]), "polarity");
        chk({31'h0, use_low_o}, 32'(k[1]), "unsynced switch");
      end
    end
    $display("test polarity done");
    // Synchronised switching waits for a falling edge of the polarised carrier.
    for (int p = 0; p < 2; p++) begin
      want_low_i <= 1'b0;
      carrier_i <= !p[0];
      bus(1'b1, DSM_CARH_ADDR, 32'(8'h20 | (p << 6)), 4'hf);
      want_low_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk({31'h0, use_low_o}, 32'h0, "held before edge");
      carrier_i <= p[0];
      repeat (3) @(posedge clk_i);
      chk({31'h0, use_low_o}, 32'h1, "switched after edge");
      want_low_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, use_low_o}, 32'h0, "back to high");
    end
    $display("test sync done");
    wrap_up();
  end
endmodule
`default_nettype wire
